// ### rtl/qsb_sram_core.sv
// burst sram core: command capture, read and write burst machines
`timescale 1ns/1ps
//
// Behaviour
// - x8: nibble masks gate bits 0-3, 4-7
// - masks sampled anew on every beat edge
// - x9: one mask gates all nine bits
// - x18: two masks gate two nine-bit lanes
// - x36: four masks, one per lane
// - two internal low bits extend address
// - beat offsets always 0,1,2,3 linear
// - burst ends after fourth beat
// - read and write machines run independently
// - an accepted read wins when both strobes low
// - write machine advances on input clock edges, read machine on output clock edges
// - strobes and address taken on K rise
// - same-kind request on next edge ignored
// - write beats on K, K#, K, K#
// - read beats on C#, C; fallback K
module qsb_sram_core
  import qsb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // organisation, held static in operation
  input wire qsb_org_t org_i,
  // input and output clock pairs, sampled as levels
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic c_i,
  input wire logic c_n_i,
  // command and address
  input wire logic read_n_i,
  input wire logic write_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // write data and masks
  input wire logic [DATA_W-1:0] data_i,
  input wire logic low_nibble_write_mask_n_i,
  input wire logic high_nibble_write_mask_n_i,
  input wire logic lane0_write_mask_n_i,
  input wire logic lane1_write_mask_n_i,
  input wire logic lane2_write_mask_n_i,
  input wire logic lane3_write_mask_n_i,
  // read data
  output logic [DATA_W-1:0] q_o,
  output logic q_oe_o,
  // status
  output logic rd_busy_o,
  output logic wr_busy_o
);

  // ****************************************
  // clock edge detection
  // ****************************************
  logic k_ff, nxt_k;
  logic k_n_ff, nxt_k_n;
  logic c_ff, nxt_c;
  logic c_n_ff, nxt_c_n;
  logic k_rise, k_n_rise, c_rise, c_n_rise, out_rise, out_n_rise;
  logic out_clk_parked;

  always_comb begin
    nxt_k = k_i;
    nxt_k_n = k_n_i;
    nxt_c = c_i;
    nxt_c_n = c_n_i;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      k_ff <= 1'b1;
      k_n_ff <= 1'b1;
      c_ff <= 1'b1;
      c_n_ff <= 1'b1;
    end else begin
      k_ff <= nxt_k;
      k_n_ff <= nxt_k_n;
      c_ff <= nxt_c;
      c_n_ff <= nxt_c_n;
    end
  end

  assign k_rise = k_i & ~k_ff;
  assign k_n_rise = k_n_i & ~k_n_ff;
  assign c_rise = c_i & ~c_ff;
  assign c_n_rise = c_n_i & ~c_n_ff;
  // both output clocks parked high: launch on the input pair instead
  assign out_clk_parked = c_i & c_n_i;
  assign out_rise = out_clk_parked ? k_rise : c_rise;
  assign out_n_rise = out_clk_parked ? k_n_rise : c_n_rise;

  // ****************************************
  // command capture
  // ****************************************
  logic rd_last_ff, nxt_rd_last;
  logic wr_last_ff, nxt_wr_last;
  logic rd_accept, wr_accept;
  // a read that was refused still lets a write through on the same edge
  assign rd_accept = k_rise & ~read_n_i & ~rd_last_ff;
  assign wr_accept = k_rise & ~write_n_i & ~wr_last_ff
                     & ~rd_accept;

  always_comb begin
    nxt_rd_last = rd_last_ff;
    nxt_wr_last = wr_last_ff;
    if (k_rise) begin
      nxt_rd_last = rd_accept;
      nxt_wr_last = wr_accept;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_last_ff <= 1'b0;
      wr_last_ff <= 1'b0;
    end else begin
      rd_last_ff <= nxt_rd_last;
      wr_last_ff <= nxt_wr_last;
    end
  end

  // ****************************************
  // storage array
  // ****************************************
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] bit_en;
  logic wr_beat;
  logic [BEAT_W-1:0] wr_off;
  logic [MEM_AW-1:0] wr_mem_addr;
  qsb_lane_enable u_lane_enable (
    .org_i(org_i),
    .low_nibble_write_mask_n_i(low_nibble_write_mask_n_i),
    .high_nibble_write_mask_n_i(high_nibble_write_mask_n_i),
    .lane_write_mask_n_i({lane3_write_mask_n_i, lane2_write_mask_n_i,
                          lane1_write_mask_n_i, lane0_write_mask_n_i}),
    .bit_en_o(bit_en)
  );

  // masks come straight from the pins on each beat edge
  always_ff @(posedge ref_clk_i) begin
    if (wr_beat) begin
      mem[wr_mem_addr] <= (mem[wr_mem_addr] & ~bit_en)
                          | (data_i & bit_en);
    end
  end

  // ****************************************
  // write burst machine
  // ****************************************
  qsb_wr_state_t wr_state_ff, nxt_wr_state;
  logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic [ADDR_W-1:0] wr_pend_addr_ff, nxt_wr_pend_addr;
  logic wr_pend_ff, nxt_wr_pend;

  always_comb begin
    nxt_wr_state = wr_state_ff;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_pend_addr = wr_pend_addr_ff;
    nxt_wr_pend = wr_pend_ff;
    wr_beat = 1'b0;
    wr_off = BEAT0;
    if (wr_accept && wr_state_ff != WR_IDLE) begin
      // next burst queued behind the running one
      nxt_wr_pend = 1'b1;
      nxt_wr_pend_addr = addr_i;
    end
    case (wr_state_ff)
      WR_IDLE: begin
        if (wr_accept) begin
          nxt_wr_addr = addr_i;
          nxt_wr_state = WR_ARMED;
        end
      end
      WR_ARMED: begin
        if (k_rise) begin
          wr_beat = 1'b1;
          wr_off = BEAT0;
          nxt_wr_state = WR_BEAT1;
        end
      end
      WR_BEAT1: begin
        if (k_n_rise) begin
          wr_beat = 1'b1;
          wr_off = BEAT1;
          nxt_wr_state = WR_BEAT2;
        end
      end
      WR_BEAT2: begin
        if (k_rise) begin
          wr_beat = 1'b1;
          wr_off = BEAT2;
          nxt_wr_state = WR_BEAT3;
        end
      end
      WR_BEAT3: begin
        if (k_n_rise) begin
          wr_beat = 1'b1;
          wr_off = BEAT3;
          if (wr_pend_ff) begin
            nxt_wr_addr = wr_pend_addr_ff;
            nxt_wr_pend = 1'b0;
            nxt_wr_state = WR_ARMED;
          end else begin
            nxt_wr_state = WR_IDLE;
          end
        end
      end
      default: begin
        nxt_wr_state = WR_IDLE;
      end
    endcase
  end

  assign wr_mem_addr = {wr_addr_ff, wr_off};
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_state_ff <= WR_IDLE;
      wr_addr_ff <= ADDR_RST;
      wr_pend_addr_ff <= ADDR_RST;
      wr_pend_ff <= 1'b0;
    end else begin
      wr_state_ff <= nxt_wr_state;
      wr_addr_ff <= nxt_wr_addr;
      wr_pend_addr_ff <= nxt_wr_pend_addr;
      wr_pend_ff <= nxt_wr_pend;
    end
  end

  // ****************************************
  // read burst machine
  // ****************************************
  // runs beside the writer; a same-cycle read of a written word sees old data
  qsb_rd_state_t rd_state_ff, nxt_rd_state;
  logic [ADDR_W-1:0] rd_addr_ff, nxt_rd_addr;
  logic [ADDR_W-1:0] rd_pend_addr_ff, nxt_rd_pend_addr;
  logic rd_pend_ff, nxt_rd_pend;
  logic [DATA_W-1:0] q_ff, nxt_q;
  logic q_oe_ff, nxt_q_oe;
  logic rd_beat;
  logic [BEAT_W-1:0] rd_off;

  always_comb begin
    nxt_rd_state = rd_state_ff;
    nxt_rd_addr = rd_addr_ff;
    nxt_rd_pend_addr = rd_pend_addr_ff;
    nxt_rd_pend = rd_pend_ff;
    rd_beat = 1'b0;
    rd_off = BEAT0;
    if (rd_accept && rd_state_ff != RD_IDLE) begin
      nxt_rd_pend = 1'b1;
      nxt_rd_pend_addr = addr_i;
    end
    case (rd_state_ff)
      RD_IDLE: begin
        if (rd_accept) begin
          nxt_rd_addr = addr_i;
          nxt_rd_state = RD_ARMED;
        end
      end
      RD_ARMED: begin
        if (out_n_rise) begin
          rd_beat = 1'b1;
          rd_off = BEAT0;
          nxt_rd_state = RD_BEAT1;
        end
      end
      RD_BEAT1: begin
        if (out_rise) begin
          rd_beat = 1'b1;
          rd_off = BEAT1;
          nxt_rd_state = RD_BEAT2;
        end
      end
      RD_BEAT2: begin
        if (out_n_rise) begin
          rd_beat = 1'b1;
          rd_off = BEAT2;
          nxt_rd_state = RD_BEAT3;
        end
      end
      RD_BEAT3: begin
        if (out_rise) begin
          rd_beat = 1'b1;
          rd_off = BEAT3;
          // a read taken on this very edge follows straight on
          if (rd_pend_ff || rd_accept) begin
            nxt_rd_addr = rd_pend_ff ? rd_pend_addr_ff : addr_i;
            nxt_rd_pend = rd_pend_ff & rd_accept;
            nxt_rd_state = RD_ARMED;
          end else begin
            nxt_rd_state = RD_IDLE;
          end
        end
      end
      default: begin
        nxt_rd_state = RD_IDLE;
      end
    endcase
  end

  // output drive holds from one launch edge to the next output edge
  always_comb begin
    nxt_q = q_ff;
    nxt_q_oe = q_oe_ff;
    if (rd_beat) begin
      nxt_q = mem[{rd_addr_ff, rd_off}];
      nxt_q_oe = 1'b1;
    end else if (out_rise || out_n_rise) begin
      nxt_q_oe = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_state_ff <= RD_IDLE;
      rd_addr_ff <= ADDR_RST;
      rd_pend_addr_ff <= ADDR_RST;
      rd_pend_ff <= 1'b0;
      q_ff <= DATA_RST;
      q_oe_ff <= 1'b0;
    end else begin
      rd_state_ff <= nxt_rd_state;
      rd_addr_ff <= nxt_rd_addr;
      rd_pend_addr_ff <= nxt_rd_pend_addr;
      rd_pend_ff <= nxt_rd_pend;
      q_ff <= nxt_q;
      q_oe_ff <= nxt_q_oe;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign q_o = q_ff;
  assign q_oe_o = q_oe_ff;
  assign rd_busy_o = (rd_state_ff != RD_IDLE);
  assign wr_busy_o = (wr_state_ff != WR_IDLE);

endmodule

// ### rtl/qsb_pkg.sv
// shared constants and types of the burst sram core
package qsb_pkg;

  // ****************************************
  // datapath and address widths
  // ****************************************
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int NUM_LANES = 4;
  localparam int NIB_W = 4;
  localparam int ADDR_W = 8;
  localparam int BEAT_W = 2;
  localparam int MEM_AW = ADDR_W + BEAT_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int BURST_LEN = 4;

  // ****************************************
  // beat offsets inside a burst
  // ****************************************
  localparam logic [BEAT_W-1:0] BEAT0 = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT1 = 2'h1;
  localparam logic [BEAT_W-1:0] BEAT2 = 2'h2;
  localparam logic [BEAT_W-1:0] BEAT3 = 2'h3;

  // ****************************************
  // organisation select and reset values
  // ****************************************
  typedef enum logic [1:0] {
    ORG_X8  = 2'h0,
    ORG_X9  = 2'h1,
    ORG_X18 = 2'h2,
    ORG_X36 = 2'h3
  } qsb_org_t;

  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;

  // ****************************************
  // burst machine states
  // ****************************************
  typedef enum logic [4:0] {
    WR_IDLE  = 5'h01,
    WR_ARMED = 5'h02,
    WR_BEAT1 = 5'h04,
    WR_BEAT2 = 5'h08,
    WR_BEAT3 = 5'h10
  } qsb_wr_state_t;

  typedef enum logic [4:0] {
    RD_IDLE  = 5'h01,
    RD_ARMED = 5'h02,
    RD_BEAT1 = 5'h04,
    RD_BEAT2 = 5'h08,
    RD_BEAT3 = 5'h10
  } qsb_rd_state_t;

endpackage

// ### rtl/qsb_lane_enable.sv
// per-bit write enable decode from organisation and active-low masks
`timescale 1ns/1ps
module qsb_lane_enable
  import qsb_pkg::*;
(
  // organisation
  input wire qsb_org_t org_i,
  // masks sampled on the current beat edge
  input wire logic low_nibble_write_mask_n_i,
  input wire logic high_nibble_write_mask_n_i,
  input wire logic [NUM_LANES-1:0] lane_write_mask_n_i,
  // per-bit write enable
  output logic [DATA_W-1:0] bit_en_o
);

  logic [DATA_W-1:0] x36_en;

  // ****************************************
  // one nine-bit lane per mask
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++) begin : g_lane
      assign x36_en[g*LANE_W +: LANE_W] =
        {LANE_W{~lane_write_mask_n_i[g]}};
    end
  endgenerate

  always_comb begin
    bit_en_o = '0;
    case (org_i)
      ORG_X8: begin
        bit_en_o[NIB_W-1:0] =
          {NIB_W{~low_nibble_write_mask_n_i}};
        bit_en_o[2*NIB_W-1:NIB_W] =
          {NIB_W{~high_nibble_write_mask_n_i}};
      end
      ORG_X9: begin
        bit_en_o[LANE_W-1:0] =
          {LANE_W{~lane_write_mask_n_i[0]}};
      end
      ORG_X18: begin
        bit_en_o[2*LANE_W-1:0] = x36_en[2*LANE_W-1:0];
      end
      ORG_X36: begin
        bit_en_o = x36_en;
      end
      default: begin
        bit_en_o = '0;
      end
    endcase
  end

endmodule

// ### test/qsb_ctl.sv
// controller-side clock pairs for the burst sram core
`timescale 1ns/1ps
module qsb_ctl
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // hold both output clocks high
  input wire logic c_hold_i,
  // clock pairs and phase
  output logic k_o,
  output logic k_n_o,
  output logic c_o,
  output logic c_n_o,
  output logic [1:0] ph_o
);
  logic [1:0] nxt_ph;
  always_comb nxt_ph = ph_o + 2'h1;
  // free running: the device needs a steady k
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      ph_o <= 2'h0;
    else
      ph_o <= nxt_ph;
  end
  assign k_o = ~ph_o[1];
  assign k_n_o = ph_o[1];
  assign c_o = c_hold_i | ~ph_o[1];
  assign c_n_o = c_hold_i | ph_o[1];
endmodule

// ### test/qsb_chk_properties.sv
// port-level checks of the burst sram core
`timescale 1ns/1ps
module qsb_chk
  import qsb_pkg::*;
#(parameter int K_PER = 4)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // clocks and strobes
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic c_i,
  input wire logic c_n_i,
  input wire logic read_n_i,
  input wire logic write_n_i,
  // outputs
  input wire logic [DATA_W-1:0] q_o,
  input wire logic q_oe_o,
  input wire logic rd_busy_o,
  input wire logic wr_busy_o
);
  localparam int B_MAX = 3 * K_PER;
  logic [3:0] edg_ff, nxt_edg;
  logic [7:0] rdc_ff, wrc_ff, nxt_rdc, nxt_wrc;
  logic kr, knr, orise;
  always_comb begin
    nxt_edg = {k_i, k_n_i, c_i, c_n_i};
    // a taken command restarts the count: legal queued bursts run on
    nxt_rdc = (!rd_busy_o || (kr && !read_n_i)) ? 8'h00 : rdc_ff + 8'h01;
    nxt_wrc = (!wr_busy_o || (kr && !write_n_i)) ? 8'h00 : wrc_ff + 8'h01;
  end
  // pins high at release give no rise
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      edg_ff <= 4'hf;
      rdc_ff <= 8'h00;
      wrc_ff <= 8'h00;
    end else begin
      edg_ff <= nxt_edg;
      rdc_ff <= nxt_rdc;
      wrc_ff <= nxt_wrc;
    end
  end
  assign kr = k_i & ~edg_ff[3];
  assign knr = k_n_i & ~edg_ff[2];
  assign orise = (c_i & c_n_i) ? (kr | knr) :
    ((c_i & ~edg_ff[1]) | (c_n_i & ~edg_ff[0]));
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_rd_start;
    kr && !read_n_i && !rd_busy_o |=> rd_busy_o;
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("read not started");
  property p_wr_start;
    kr && read_n_i && !write_n_i && !wr_busy_o |=> wr_busy_o;
  endproperty
  a_wr_start: assert property (p_wr_start)
    else $error("write not started");
  property p_rd_wins;
    kr && !read_n_i && !write_n_i && !rd_busy_o && !wr_busy_o
      |=> !wr_busy_o;
  endproperty
  a_rd_wins: assert property (p_rd_wins)
    else $error("write started beside read");
  property p_nop;
    kr && read_n_i && write_n_i && !rd_busy_o && !wr_busy_o
      |=> !rd_busy_o && !wr_busy_o;
  endproperty
  a_nop: assert property (p_nop)
    else $error("burst started on no-op");
  property p_busy_k;
    $rose(rd_busy_o) || $rose(wr_busy_o) |-> $past(kr);
  endproperty
  a_busy_k: assert property (p_busy_k)
    else $error("burst started off a k rise");
  property p_q_moves;
    !$stable(q_o) |-> $past(orise);
  endproperty
  a_q_moves: assert property (p_q_moves)
    else $error("read data moved off an output edge");
  property p_first_beat;
    kr && !read_n_i && !rd_busy_o |-> ##[1:K_PER] $rose(q_oe_o);
  endproperty
  a_first_beat: assert property (p_first_beat)
    else $error("first read beat late");
  property p_oe_cause;
    $rose(q_oe_o) |-> $past(orise) && $past(rd_busy_o);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("drive enable without read beat");
  property p_rd_len;
    rdc_ff <= B_MAX;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read burst too long");
  property p_wr_len;
    wrc_ff <= B_MAX;
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write burst too long");
endmodule
bind qsb_sram_core qsb_chk u_chk (.ref_clk_i, .arst_n_i, .k_i, .k_n_i,
  .c_i, .c_n_i, .read_n_i, .write_n_i, .q_o, .q_oe_o, .rd_busy_o,
  .wr_busy_o);

// ### test/quad_rate_sram_byte_write_burst_bench.sv
// self-checking bench of the burst sram core
`timescale 1ns/1ps
module quad_rate_sram_byte_write_burst_bench;
  import qsb_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hold = 1'b0;
  qsb_org_t org = ORG_X36;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [ADDR_W-1:0] addr = ADDR_RST;
  logic [DATA_W-1:0] din = DATA_RST;
  logic [5:0] msk = 6'h3f;
  logic k, kn, c, cn, oe, rbusy, wbusy;
  logic [1:0] ph;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  int n_mismatch = 0;
  int checked = 0;
  qsb_ctl ctl (.ref_clk_i(clk), .arst_n_i(arst_n), .c_hold_i(hold),
    .k_o(k), .k_n_o(kn), .c_o(c), .c_n_o(cn), .ph_o(ph));
  qsb_sram_core dut (.ref_clk_i(clk), .arst_n_i(arst_n), .org_i(org),
    .k_i(k), .k_n_i(kn), .c_i(c), .c_n_i(cn), .read_n_i(rd_n),
    .write_n_i(wr_n), .addr_i(addr), .data_i(din),
    .low_nibble_write_mask_n_i(msk[0]),
    .high_nibble_write_mask_n_i(msk[1]),
    .lane0_write_mask_n_i(msk[2]), .lane1_write_mask_n_i(msk[3]),
    .lane2_write_mask_n_i(msk[4]), .lane3_write_mask_n_i(msk[5]),
    .q_o(q), .q_oe_o(oe), .rd_busy_o(rbusy), .wr_busy_o(wbusy));
  initial forever #5 clk = ~clk;
  function automatic logic [DATA_W-1:0] ben(logic [5:0] m);
    case (org)
      ORG_X8: ben = {28'h0, {4{~m[1]}}, {4{~m[0]}}};
      ORG_X9: ben = {27'h0, {9{~m[2]}}};
      ORG_X18: ben = {18'h0, {9{~m[3]}}, {9{~m[2]}}};
      default: ben = {{9{~m[5]}}, {9{~m[4]}}, {9{~m[3]}}, {9{~m[2]}}};
    endcase
  endfunction
  function automatic logic [DATA_W-1:0] rnd();
    logic [63:0] r;
    r = {$urandom(), $urandom()};
    return r[DATA_W-1:0];
  endfunction
  // old phase seen at the edge; drive lands in phase p+1
  task automatic at(input logic [1:0] p);
    @(posedge clk iff ph == p);
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input bit rm, input bit dbl);
    logic [5:0] m;
    logic [DATA_W-1:0] d;
    logic [MEM_AW-1:0] w;
    at(2'h3);
    wr_n <= 1'b0;
    addr <= a;
    at(2'h0);
    wr_n <= !dbl;
    addr <= a ^ 8'h01;
    for (int b = 0; b < BURST_LEN; b++) begin
      at(b[0] ? 2'h1 : 2'h3);
      m = rm ? 6'($urandom) : 6'h00;
      d = rnd();
      din <= d;
      msk <= m;
      if (b == 1)
        wr_n <= 1'b1;
      w = {a, b[1:0]};
      mem[w] = (mem[w] & ~ben(m)) | (d & ben(m));
    end
  endtask
  task automatic rd(input logic [7:0] a, input bit both);
    logic [DATA_W-1:0] wm;
    logic [MEM_AW-1:0] w;
    wm = ben(6'h00);
    at(2'h3);
    rd_n <= 1'b0;
    addr <= a;
    // a wrongly started write would corrupt a
    if (both) begin
      wr_n <= 1'b0;
      msk <= 6'h00;
      din <= rnd();
    end
    at(2'h0);
    rd_n <= 1'b1;
    if (both)
      wr_n <= 1'b1;
    for (int b = 0; b < BURST_LEN; b++) begin
      at(b[0] ? 2'h0 : 2'h2);
      #1;
      w = {a, b[1:0]};
      chk(q & wm, mem[w] & wm);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  // *********
  // scenarios
  // *********
  initial begin
    logic [7:0] a;
    void'($urandom(32'h8065e75f));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (int o = 0; o < 4; o++) begin
      at(2'h1);
      org <= qsb_org_t'(o[1:0]);
      a = 8'($urandom);
      wr(a, 1'b0, 1'b0);
      wr(a, 1'b1, 1'b0);
      rd(a, 1'b0);
      $display("org test %0d done", o);
    end
    fork
      wr(a ^ 8'h80, 1'b1, 1'b0);
      begin
        at(2'h3);
        rd(a, 1'b0);
      end
    join
    rd(a ^ 8'h80, 1'b0);
    $display("overlap test done");
    fork
      wr(a ^ 8'h10, 1'b0, 1'b0);
      begin
        at(2'h3);
        at(2'h3);
        wr(a ^ 8'h20, 1'b0, 1'b0);
      end
    join
    fork
      rd(a ^ 8'h10, 1'b0);
      begin
        at(2'h3);
        at(2'h3);
        rd(a ^ 8'h20, 1'b0);
      end
    join
    $display("back-to-back test done");
    wr(a ^ 8'h41, 1'b0, 1'b0);
    wr(a ^ 8'h40, 1'b1, 1'b1);
    rd(a ^ 8'h41, 1'b0);
    $display("repeat test done");
    rd(a, 1'b1);
    rd(a, 1'b0);
    $display("both strobes test done");
    at(2'h1);
    hold <= 1'b1;
    rd(a ^ 8'h40, 1'b0);
    $display("held clocks test done");
    conclude();
  end
endmodule
